// ### rtl/tar_interval_timer.sv
`timescale 1ns/1ps
module tar_interval_timer
  import tar_pkg::*;
#(
  parameter int UNIT_CYC = IVL_UNIT_CYC
)(
  input  wire logic       i_ref_clk,  // controller clock
  input  wire logic       i_rst_n,    // sync reset, active low
  input  wire logic       i_run,      // count while high, clear when low
  input  wire logic [7:0] i_units,    // interval in 0.1 s steps
  output logic            o_done      // one cycle when interval elapsed
);

  localparam logic [31:0] UNIT_LAST = 32'(UNIT_CYC - 1);

  logic [31:0] pre_q, pre_d;
  logic [7:0]  unit_q, unit_d;
  logic        wrap;

  always_comb
  begin
    wrap   = (pre_q == UNIT_LAST);
    pre_d  = pre_q;
    unit_d = unit_q;
    o_done = 1'b0;
    if (!i_run)
    begin
      pre_d  = '0;
      unit_d = '0;
    end
    else if (wrap)
    begin
      pre_d  = '0;
      unit_d = unit_q + 8'h01;
      o_done = (unit_q == i_units - 8'h01);
    end
    else
    begin
      pre_d = pre_q + 32'h1;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      pre_q  <= '0;
      unit_q <= '0;
    end
    else
    begin
      pre_q  <= pre_d;
      unit_q <= unit_d;
    end
  end

endmodule : tar_interval_timer

// ### rtl/tar_pkg.sv
// What this block does
// R1: an eligible trip with retries enabled is cleared and restarted by the block, with no alarm.
// R2: a trip beyond the programmed retry count raises the alarm and ends all further retries.
// R3: the retry limit takes 0 (retries off) or 1 to 10 attempts.
// R4: each attempt waits the programmed interval, 0.5 s to 20.0 s, before the reset command.
// R5: only the eight overcurrent, overvoltage, overheat and overload trips may be retried.
// R6: an output set to function 26 is high exactly while a retry sequence runs.
// R7: the attempt count clears once normal running resumes, so a later trip starts afresh.
package tar_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_LIMIT    = 8'h00;
  localparam logic [7:0] REG_INTERVAL = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_OUT_SEL  = 8'h14;

  localparam logic [3:0] LIMIT_RST    = 4'h0;
  localparam logic [7:0] INTERVAL_RST = 8'h05;
  localparam logic [7:0] OUT_SEL_RST  = 8'h00;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  localparam logic [3:0] RETRY_MAX    = 4'ha;
  localparam logic [7:0] IVL_MIN      = 8'h05;
  localparam logic [7:0] IVL_MAX      = 8'hc8;
  localparam logic [7:0] FUNC_RETRY   = 8'h1a;

  // irq status / mask bit positions
  localparam int IRQ_TRIP    = 0;
  localparam int IRQ_RESET   = 1;
  localparam int IRQ_ALARM   = 2;
  localparam int IRQ_RECOVER = 3;
  localparam int IRQ_W       = 4;

  // status register field positions
  localparam int ST_CNT_LSB  = 0;
  localparam int ST_ACT_BIT  = 4;
  localparam int ST_ALM_BIT  = 5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int IVL_UNIT_NS   = 100_000_000;  // interval step 0.1 s
  localparam int IVL_UNIT_CYC  = IVL_UNIT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // trip causes: codes below TRIP_RETRY_LIMIT may be retried
  // ----------------------------------------------------------------
  localparam logic [3:0] TRIP_OVERCURRENT  = 4'h0;
  localparam logic [3:0] TRIP_OVERVOLTAGE  = 4'h1;
  localparam logic [3:0] TRIP_SINK_HOT     = 4'h2;
  localparam logic [3:0] TRIP_INTERNAL_HOT = 4'h3;
  localparam logic [3:0] TRIP_MOTOR_HOT    = 4'h4;
  localparam logic [3:0] TRIP_BRAKE_HOT    = 4'h5;
  localparam logic [3:0] TRIP_MOTOR_OL     = 4'h6;
  localparam logic [3:0] TRIP_DRIVE_OL     = 4'h7;
  localparam logic [3:0] TRIP_RETRY_LIMIT  = 4'h8;

  typedef struct packed {
    logic       valid;
    logic [3:0] cause;
  } tar_trip_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_RECOVER,
    ST_ALARM
  } tar_state_e;

endpackage : tar_pkg

// ### rtl/tar_retry_ctrl.sv
`timescale 1ns/1ps
module tar_retry_ctrl
  import tar_pkg::*;
#(
  parameter int UNIT_CYC = IVL_UNIT_CYC
)(
  input  wire logic        i_ref_clk,              // controller clock
  input  wire logic        i_rst_n,                // sync reset, active low
  input  wire tar_trip_s   i_trip,                 // trip event and cause
  input  wire logic        i_run_ok,               // normal running resumed
  input  wire logic        i_alarm_reset,          // operator alarm reset
  input  wire logic [7:0]  i_addr,                 // register byte address
  input  wire logic [31:0] i_wr_data,              // register write data
  input  wire logic        i_wr,                   // write strobe
  input  wire logic        i_rd,                   // read strobe
  output logic [31:0]      o_rd_data,              // read data, next cycle
  output logic             o_reset_cmd,            // internal reset pulse
  output logic             o_fault_alarm_output,   // alarm level
  output logic             o_auto_retry_active,    // retry in progress
  output logic             o_dout,                 // selectable terminal
  output logic             o_irq                   // interrupt level
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [3:0]  retry_limit_setting_q, retry_limit_setting_d;
  logic [7:0]  retry_interval_setting_q, retry_interval_setting_d;
  logic [7:0]  output_terminal_function_select_q;
  logic [7:0]  output_terminal_function_select_d;
  logic [IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
  logic [31:0] rd_data_d;
  logic [IRQ_W-1:0] evt;
  tar_state_e  state_q, state_d;
  logic [3:0]  cnt_q, cnt_d;

  always_comb
  begin
    retry_limit_setting_d             = retry_limit_setting_q;
    retry_interval_setting_d          = retry_interval_setting_q;
    output_terminal_function_select_d = output_terminal_function_select_q;
    irq_mask_d                        = irq_mask_q;
    irq_stat_d                        = irq_stat_q;
    rd_data_d                         = '0;
    if (i_wr)
    begin
      case (i_addr)
        REG_LIMIT:
          // above the top count is held at the top, not wrapped
          retry_limit_setting_d = (i_wr_data[7:0] > 8'(RETRY_MAX)) ?
                                  RETRY_MAX : i_wr_data[3:0];  // [R3]
        REG_INTERVAL:
          if (i_wr_data[7:0] < IVL_MIN)
            retry_interval_setting_d = IVL_MIN;                // [R4]
          else if (i_wr_data[7:0] > IVL_MAX)
            retry_interval_setting_d = IVL_MAX;                // [R4]
          else
            retry_interval_setting_d = i_wr_data[7:0];
        REG_IRQ_MASK: irq_mask_d = i_wr_data[IRQ_W-1:0];
        REG_OUT_SEL:  output_terminal_function_select_d = i_wr_data[7:0];
        default: ;
      endcase
    end
    if (i_rd)
    begin
      case (i_addr)
        REG_LIMIT:    rd_data_d[3:0] = retry_limit_setting_q;
        REG_INTERVAL: rd_data_d[7:0] = retry_interval_setting_q;
        REG_STATUS:
        begin
          rd_data_d[ST_CNT_LSB +: 4] = cnt_q;
          rd_data_d[ST_ACT_BIT]      = o_auto_retry_active;
          rd_data_d[ST_ALM_BIT]      = o_fault_alarm_output;
        end
        REG_IRQ_STAT:
        begin
          rd_data_d[IRQ_W-1:0] = irq_stat_q;
          irq_stat_d           = '0;
        end
        REG_IRQ_MASK: rd_data_d[IRQ_W-1:0] = irq_mask_q;
        REG_OUT_SEL:  rd_data_d[7:0] = output_terminal_function_select_q;
        default: ;
      endcase
    end
    // an event in the clearing read's cycle still lands
    irq_stat_d = irq_stat_d | evt;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      retry_limit_setting_q             <= LIMIT_RST;
      retry_interval_setting_q          <= INTERVAL_RST;
      output_terminal_function_select_q <= OUT_SEL_RST;
      irq_mask_q                        <= IRQ_MASK_RST;
      irq_stat_q                        <= '0;
      o_rd_data                         <= '0;
    end
    else
    begin
      retry_limit_setting_q             <= retry_limit_setting_d;
      retry_interval_setting_q          <= retry_interval_setting_d;
      output_terminal_function_select_q <= output_terminal_function_select_d;
      irq_mask_q                        <= irq_mask_d;
      irq_stat_q                        <= irq_stat_d;
      o_rd_data                         <= rd_data_d;
    end
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // retry sequencer
  // ----------------------------------------------------------------
  logic       reset_cmd_d, alarm_d, timer_done, eligible, may_retry;

  tar_interval_timer #(
    .UNIT_CYC (UNIT_CYC)
  ) u_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_run     (state_q == ST_WAIT),
    .i_units   (retry_interval_setting_q),
    .o_done    (timer_done)
  );

  always_comb
  begin
    eligible    = i_trip.cause < TRIP_RETRY_LIMIT;                  // [R5]
    // limit 0 makes every trip fail this test, so retries are off
    may_retry   = eligible && (cnt_q < retry_limit_setting_q);      // [R2]
    state_d     = state_q;
    cnt_d       = cnt_q;
    reset_cmd_d = 1'b0;
    alarm_d     = o_fault_alarm_output;
    evt         = '0;
    case (state_q)
      ST_IDLE, ST_RECOVER:
        if (i_trip.valid)
        begin
          evt[IRQ_TRIP] = 1'b1;
          if (may_retry)
          begin
            state_d = ST_WAIT;                                       // [R1]
            cnt_d   = cnt_q + 4'h1;
          end
          else
          begin
            state_d        = ST_ALARM;                               // [R2]
            alarm_d        = 1'b1;                                   // [R5]
            evt[IRQ_ALARM] = 1'b1;
          end
        end
        else if (state_q == ST_RECOVER && i_run_ok)
        begin
          state_d          = ST_IDLE;
          cnt_d            = '0;                                     // [R7]
          evt[IRQ_RECOVER] = 1'b1;
        end
      ST_WAIT:
        if (timer_done)
        begin
          state_d        = ST_RECOVER;
          reset_cmd_d    = 1'b1;                                     // [R4]
          evt[IRQ_RESET] = 1'b1;
        end
      ST_ALARM:
        // no retries here; only the operator releases the alarm
        if (i_alarm_reset)
        begin
          state_d = ST_IDLE;
          cnt_d   = '0;
          alarm_d = 1'b0;
        end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      state_q              <= ST_IDLE;
      cnt_q                <= '0;
      o_reset_cmd          <= 1'b0;
      o_fault_alarm_output <= 1'b0;
    end
    else
    begin
      state_q              <= state_d;
      cnt_q                <= cnt_d;
      o_reset_cmd          <= reset_cmd_d;
      o_fault_alarm_output <= alarm_d;
    end
  end

  assign o_auto_retry_active = (state_q == ST_WAIT) ||
                               (state_q == ST_RECOVER);              // [R6]
  assign o_dout = o_auto_retry_active &&
                  (output_terminal_function_select_q == FUNC_RETRY); // [R6]

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [31:0] wait_cyc_q;
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || state_q != ST_WAIT)
      wait_cyc_q <= '0;
    else
      wait_cyc_q <= wait_cyc_q + 32'h1;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence eligible_trip_s;
    i_trip.valid && (state_q == ST_IDLE || state_q == ST_RECOVER) &&
    eligible;
  endsequence

  sequence retry_fire_s;
    o_reset_cmd;
  endsequence

  retry_no_alarm_a: assert property ( // [R1]
    eligible_trip_s ##0 (cnt_q < retry_limit_setting_q)
    |=> (state_q == ST_WAIT) && !o_fault_alarm_output)
    else $error("eligible trip did not start a silent retry");

  limit_alarm_a: assert property ( // [R2]
    eligible_trip_s ##0 (cnt_q >= retry_limit_setting_q)
    |=> o_fault_alarm_output && !o_auto_retry_active)
    else $error("retry count exceeded without alarm");

  limit_range_a: assert property ( // [R3]
    retry_limit_setting_q <= RETRY_MAX && cnt_q <= retry_limit_setting_q)
    else $error("retry limit or count out of range");

  interval_wait_a: assert property ( // [R4]
    retry_fire_s |-> $past(wait_cyc_q) ==
      32'(retry_interval_setting_q) * 32'(UNIT_CYC) - 32'h1)
    else $error("reset command not after the programmed interval");

  ineligible_alarm_a: assert property ( // [R5]
    i_trip.valid && !eligible &&
    (state_q == ST_IDLE || state_q == ST_RECOVER)
    |=> o_fault_alarm_output ##0 (state_q == ST_ALARM))
    else $error("ineligible trip did not raise the alarm");

  status_output_a: assert property ( // [R6]
    retry_fire_s |-> o_auto_retry_active &&
      (o_dout == (output_terminal_function_select_q == FUNC_RETRY)))
    else $error("retry status output wrong during retry");

  count_clear_a: assert property ( // [R7]
    state_q == ST_RECOVER && i_run_ok && !i_trip.valid
    |=> cnt_q == 4'h0 && !o_auto_retry_active && !o_dout)
    else $error("attempt count not cleared after recovery");

endmodule : tar_retry_ctrl

// ### verif/tar_drive_model.sv
`timescale 1ns/1ps
module tar_drive_model
  import tar_pkg::*;
(
  input  wire logic       i_ref_clk,   // controller clock
  input  wire logic       i_rst_n,     // sync reset, active low
  input  wire logic       i_fire,      // bench asks for a trip
  input  wire logic [3:0] i_cause,     // cause of that trip
  input  wire logic [1:0] i_mode,      // 0 quick, 1 slow, 2 trips again
  input  wire logic       i_reset_cmd, // reset command from the block
  output tar_trip_s       o_trip,      // trip event to the block
  output logic            o_run_ok     // drive running again
);
  logic [3:0] dly_q;
  logic [3:0] cause_q;
  logic       busy_q;

  // a drive that stays faulty trips again soon after each reset
  always_ff @(posedge i_ref_clk)
  begin
    o_trip   <= '0;
    o_run_ok <= 1'b0;
    if (!i_rst_n)
    begin
      busy_q <= 1'b0;
      dly_q  <= 4'h0;
    end
    else if (i_fire)
    begin
      o_trip  <= '{valid: 1'b1, cause: i_cause};
      cause_q <= i_cause;
    end
    else if (i_reset_cmd)
    begin
      busy_q <= 1'b1;
      dly_q  <= (i_mode == 2'h0) ? 4'h0 : (i_mode == 2'h1) ? 4'h6 : 4'h2;
    end
    else if (busy_q && dly_q != 4'h0)
      dly_q <= dly_q - 4'h1;
    else if (busy_q)
    begin
      busy_q <= 1'b0;
      if (i_mode == 2'h2)
        o_trip <= '{valid: 1'b1, cause: cause_q};
      else
        o_run_ok <= 1'b1;
    end
  end
endmodule : tar_drive_model

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import tar_pkg::*;
  localparam int UNIT = 4;
  logic        i_ref_clk = 1'b0;
  logic        i_rst_n   = 1'b0;
  logic [7:0]  i_addr    = 8'h00;
  logic [31:0] i_wr_data = 32'h0;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic        i_alarm_reset = 1'b0;
  logic        fire = 1'b0;
  logic [3:0]  cause = 4'h0;
  logic [1:0]  mode = 2'h0;
  tar_trip_s   trip;
  logic        run_ok;
  logic [31:0] o_rd_data, v;
  logic        o_reset_cmd, o_fault_alarm_output, o_auto_retry_active;
  logic        o_dout, o_irq;
  int          n_errors = 0;
  int          check_count = 0;
  int          n;

  always #50 i_ref_clk = ~i_ref_clk;

  tar_retry_ctrl #(.UNIT_CYC(UNIT)) uut (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_trip(trip), .i_run_ok(run_ok),
    .i_alarm_reset(i_alarm_reset), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .o_reset_cmd(o_reset_cmd), .o_fault_alarm_output(o_fault_alarm_output),
    .o_auto_retry_active(o_auto_retry_active), .o_dout(o_dout),
    .o_irq(o_irq));
  tar_drive_model drv (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_fire(fire), .i_cause(cause), .i_mode(mode),
    .i_reset_cmd(o_reset_cmd), .o_trip(trip), .o_run_ok(run_ok));

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr    <= a;
    i_wr_data <= d;
    i_wr      <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] got);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    got = o_rd_data;
  endtask : rd
  // trip valid stands in the cycle this returns in
  task trip_now(input logic [3:0] c);
    @(posedge i_ref_clk);
    fire  <= 1'b1;
    cause <= c;
    @(posedge i_ref_clk);
    fire <= 1'b0;
    @(negedge i_ref_clk);
  endtask : trip_now
  task release_alarm;
    @(posedge i_ref_clk);
    i_alarm_reset <= 1'b1;
    @(posedge i_ref_clk);
    i_alarm_reset <= 1'b0;
    @(negedge i_ref_clk);
    chk("alarm cleared", 32'h0, o_fault_alarm_output);
  endtask : release_alarm

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd(REG_LIMIT, v);
    chk("limit reset", {28'h0, LIMIT_RST}, v);
    rd(REG_INTERVAL, v);
    chk("interval reset", {24'h0, INTERVAL_RST}, v);
    rd(REG_OUT_SEL, v);
    chk("out sel reset", {24'h0, OUT_SEL_RST}, v);
    wr(8'h18, 32'hffff_ffff);
    rd(8'h18, v);
    chk("unmapped", 32'h0, v);
    wr(REG_STATUS, 32'hff);
    rd(REG_STATUS, v);
    chk("status ro", 32'h0, v);
    wr(REG_LIMIT, 32'hf);
    rd(REG_LIMIT, v);
    chk("limit max", 32'ha, v);
    wr(REG_INTERVAL, 32'h2);
    rd(REG_INTERVAL, v);
    chk("ivl lo", 32'h5, v);
    wr(REG_INTERVAL, 32'hff);
    rd(REG_INTERVAL, v);
    chk("ivl hi", 32'hc8, v);
    wr(REG_LIMIT, 32'h0);
    trip_now(TRIP_OVERCURRENT);
    @(negedge i_ref_clk);
    chk("limit zero alarm", 32'h1, o_fault_alarm_output);
    chk("limit zero idle", 32'h0, o_auto_retry_active);
    release_alarm();
    // sticky trip and alarm bits must not leak into the next test
    rd(REG_IRQ_STAT, v);
    chk("limit zero irq", 32'h5, v);
    $display("test settings done");
    // every cause; long interval on one, selector and mask alternate
    wr(REG_LIMIT, 32'ha);
    for (int c = 0; c < 16; c++)
    begin
      wr(REG_INTERVAL, (c == 7) ? 32'hc8 : 32'h5);
      wr(REG_OUT_SEL, c[0] ? {24'h0, FUNC_RETRY} : 32'h19);
      wr(REG_IRQ_MASK, c[0] ? 32'hf : 32'h0);
      mode <= c[1] ? 2'h1 : 2'h0;
      trip_now(c[3:0]);
      @(negedge i_ref_clk);
      if (c < 8)
      begin
        chk("retry active", 32'h1, o_auto_retry_active);
        chk("no alarm", 32'h0, o_fault_alarm_output);
        chk("status pin", {31'h0, c[0]}, o_dout);
        chk("irq", {31'h0, c[0]}, o_irq);
        n = 1;
        while (o_reset_cmd !== 1'b1 && n < 1000)
        begin
          @(negedge i_ref_clk);
          n++;
        end
        chk("reset delay", ((c == 7) ? 200 : 5) * UNIT + 1, n);
        n = 0;
        while (o_auto_retry_active !== 1'b0 && n < 20)
        begin
          @(negedge i_ref_clk);
          n++;
        end
        chk("retry over", 32'h0, o_auto_retry_active);
        chk("pin over", 32'h0, o_dout);
        rd(REG_STATUS, v); chk("count cleared", 32'h0, v);
        rd(REG_IRQ_STAT, v); chk("irq status", 32'hb, v);
        chk("irq cleared", 32'h0, o_irq);
      end
      else
      begin
        chk("other alarm", 32'h1, o_fault_alarm_output);
        chk("other idle", 32'h0, o_auto_retry_active);
        chk("alarm irq", {31'h0, c[0]}, o_irq);
        release_alarm();
        rd(REG_IRQ_STAT, v);
        chk("alarm irq status", 32'h5, v);
      end
    end
    $display("test causes done");
    // drive keeps tripping: two attempts, then alarm
    wr(REG_LIMIT, 32'h2);
    mode <= 2'h2;
    trip_now(TRIP_OVERVOLTAGE);
    // first wait is 20 cycles, so a status read fits before the reset
    rd(REG_STATUS, v);
    chk("retry status", 32'h11, v);
    n = 0;
    for (int k = 0; k < 400 && o_fault_alarm_output !== 1'b1; k++)
    begin
      @(negedge i_ref_clk);
      if (o_reset_cmd === 1'b1)
        n++;
    end
    chk("attempts", 32'h2, n);
    chk("final alarm", 32'h1, o_fault_alarm_output);
    mode <= 2'h0;
    rd(REG_STATUS, v); chk("alarm status", 32'h22, v);
    n = 0;
    repeat (30)
    begin
      @(negedge i_ref_clk);
      if (o_reset_cmd === 1'b1)
        n++;
    end
    chk("no more resets", 32'h0, n);
    release_alarm();
    rd(REG_STATUS, v); chk("status after", 32'h0, v);
    $display("test retry limit done");
    give_verdict();
  end
endmodule : tb_top
